// ===== rtl/shf_pkg.sv
// shared constants and types of the sync header multiblock crc12 framer
package shf_pkg;

    // block geometry
    localparam int BLK_DATA_W = 64;          // scrambled payload bits
    localparam int BLK_W = 66;               // payload plus two header bits
    localparam int HDR_LSB = 0;              // header sits at line bits 0..1
    localparam int DATA_LSB = 2;             // octet 0 starts at line bit 2
    localparam int MB_BLOCKS = 32;           // blocks per multiblock
    localparam int IDX_W = 5;                // block index width
    localparam logic [4:0] IDX_LAST = 5'h1f; // last block of a multiblock

    // extended multiblock and local clock
    localparam int E_W = 8;                  // width of e minus one
    localparam int LOCAL_EXTENDED_BLOCK_CLOCK_W = E_W + IDX_W;     // local clock counter width
    localparam logic [7:0] E_M1_RST = 8'h00; // one multiblock after reset
    localparam logic [12:0] LOCAL_EXTENDED_BLOCK_CLOCK_RST = 13'h0000;

    // stream word layout
    localparam int EMB_FLAG_BIT = 22;        // extended block end flag
    localparam int CMD_W = 7;                // command word, always zero
    localparam logic [4:0] PILOT_FIRST = 5'h1b; // first of the 00001 bits
    localparam logic [4:0] CMD_HI_FIRST = 5'h10; // command bits 6..4 start

    // crc
    localparam int CRC_W = 12;
    localparam logic [11:0] CRC_POLY = 12'h987;
    localparam logic [11:0] CRC_RST = 12'h000;

    // content select
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_CRC12 = 2'h0;

    // one transmitted block: header in the low bits
    typedef struct packed {
        logic [BLK_DATA_W-1:0] payload;
        logic [1:0] hdr;
    } shf_line_t;

    // framer state
    typedef enum logic [0:0] {
        SHF_WAIT_EDGE,
        SHF_RUN
    } shf_state_t;

endpackage

// ===== rtl/shf_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module shf_pair_buf #(
    parameter int W = shf_pkg::BLK_DATA_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output var logic in_ready_r,
    input wire logic [W-1:0] in_data,
    output var logic out_valid_r,
    input wire logic out_ready,
    output var logic [W-1:0] out_data_r
);

    logic [W-1:0] skid_r; // second entry, full while in_ready_r is low
    logic in_fire;        // word taken from the source
    logic pop;            // head slot free or being drained

    assign in_fire = in_valid & in_ready_r;
    assign pop = ~out_valid_r | out_ready;

    // head entry: refilled from the skid first, else from the source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (pop) begin
            if (!in_ready_r) begin
                // skid holds the older word
                out_data_r <= skid_r;
                out_valid_r <= 1'b1;
            end else begin
                out_data_r <= in_data;
                out_valid_r <= in_fire;
            end
        end
    end

    // skid entry: catches a word while the head is stalled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skid_r <= '0;
            in_ready_r <= 1'b1;
        end else if (pop) begin
            in_ready_r <= 1'b1;
        end else if (in_fire) begin
            skid_r <= in_data;
            in_ready_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/shf_framer.sv
// 64b/66b lane framer: headers, multiblocks, local clock and crc-12
// What the document asks; the receiver rules [R9] [R10] [R15] [R22] [R23] are not built here
// [R1] header at bits 0-1, scrambled octets after
// [R2] thirty-two blocks make one multiblock
// [R3] extended multiblock holds E multiblocks, E>=1
// [R4] sysref edge resets local clock phase
// [R5] local clock period is 32*E blocks
// [R6] periodic sysref must divide local clock
// [R7] header bits always complementary
// [R8] stream one sends 01, zero sends 10
// [R9] receiver finds transitions, flags 00/11
// [R10] receiver requests sysref after header errors
// [R11] one stream bit per block, 32 per word
// [R12] only crc-12 content built; others unsupported
// [R13] word ends 00001; unique in crc mode
// [R14] bit 22 flags last multiblock of extended
// [R15] fec receivers confirm pilot over multiblocks
// [R16] select zero chooses crc-12 content
// [R17] parity over 2048 payload bits, sent next
// [R18] polynomial 0x987, bits in transmission order
// [R19] crc cleared per multiblock, read after 2048
// [R20] fixed crc stream layout of parity, ones
// [R21] all seven command bits sent zero
// [R22] receiver compares crc with next parity
// [R23] receiver latency at least 46 blocks
// [R24] bit n in block n; start on edge
`timescale 1ns/1ns
`default_nettype none
module shf_framer (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sysref,
    input wire logic [shf_pkg::E_W-1:0] e_minus1,
    input wire logic [shf_pkg::SEL_W-1:0] sync_header_content_select,
    input wire logic blk_in_valid,
    output var logic blk_in_ready,
    input wire logic [shf_pkg::BLK_DATA_W-1:0] blk_in_data,
    output var shf_pkg::shf_line_t line_block_r,
    output var logic line_valid_r,
    input wire logic line_ready,
    output var logic local_extended_block_clock_r,
    output var logic aligned_r,
    output var logic content_unsupported_r
);
    logic rst_meta_r;                         // reset release, first stage
    logic rst_n_r;                            // released reset copy
    logic sysref_s1_r;                        // sysref pin, first stage
    logic sysref_s2_r;                        // second stage
    logic sysref_s3_r;                        // third stage
    logic sysref_lvl_r;                       // agreed sysref level
    logic sysref_edge;                        // agreed rising edge
    logic [shf_pkg::E_W-1:0] e_cfg_r;         // e minus one in use
    logic [shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_W-1:0] local_extended_block_clock_cnt_r;   // block slot in extended
    logic [shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_W-1:0] local_extended_block_clock_cnt_nxt;
    logic [shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_W-1:0] local_extended_block_clock_last;    // 32*E - 1
    logic phase_ok;                           // sysref lands on boundary
    shf_pkg::shf_state_t state_r;             // framer state
    logic [shf_pkg::IDX_W-1:0] blk_idx_r;     // block in multiblock
    logic [shf_pkg::E_W-1:0] mb_idx_r;        // multiblock in extended
    logic [shf_pkg::CRC_W-1:0] crc_run_r;     // running shift stages
    logic [shf_pkg::CRC_W-1:0] crc_nxt;       // stages after this block
    logic [shf_pkg::CRC_W-1:0] crc_hold_r;    // parity of last multiblock
    logic [shf_pkg::MB_BLOCKS-1:0] stream_word; // current stream word
    logic emb_last;                           // last multiblock of extended
    logic sbit;                               // stream bit of this block
    logic buf_valid;                          // buffered word present
    logic [shf_pkg::BLK_DATA_W-1:0] buf_data; // buffered scrambled word
    logic take;                               // framer may accept a block
    logic fire;                               // block emitted this cycle

    // reset release through two flip-flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // sysref pin synchroniser, three stages
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sysref_s1_r <= 1'b0;
            sysref_s2_r <= 1'b0;
            sysref_s3_r <= 1'b0;
        end else begin
            sysref_s1_r <= sysref;
            sysref_s2_r <= sysref_s1_r;
            sysref_s3_r <= sysref_s2_r;
        end
    end

    // level changes only once the last two stages agree
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sysref_lvl_r <= 1'b0;
        end else if (sysref_s2_r == sysref_s3_r) begin
            sysref_lvl_r <= sysref_s2_r;
        end
    end
    assign sysref_edge = (sysref_s2_r == sysref_s3_r) & sysref_s2_r &
                         ~sysref_lvl_r;

    // e is taken on each sysref edge so the clock period moves cleanly
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            e_cfg_r <= shf_pkg::E_M1_RST;
        end else if (sysref_edge) begin
            e_cfg_r <= e_minus1; // [R3]
        end
    end

    // one extended multiblock is e multiblocks of 32 block slots
    assign local_extended_block_clock_last = {e_cfg_r, shf_pkg::IDX_LAST}; // [R5]
    // a periodic sysref that divides the period keeps the phase
    assign phase_ok = (local_extended_block_clock_cnt_r == local_extended_block_clock_last); // [R6]
    // local clock counter, one slot per core clock cycle
    always_comb begin
        if (sysref_edge) begin
            local_extended_block_clock_cnt_nxt = shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST; // [R4]
        end else if (local_extended_block_clock_cnt_r == local_extended_block_clock_last) begin
            local_extended_block_clock_cnt_nxt = shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST; // [R5]
        end else begin
            local_extended_block_clock_cnt_nxt = local_extended_block_clock_cnt_r + 13'h0001;
        end
    end

    // counter and its registered edge pulse
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            local_extended_block_clock_cnt_r <= shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST;
            local_extended_block_clock_r <= 1'b0;
        end else begin
            local_extended_block_clock_cnt_r <= local_extended_block_clock_cnt_nxt;
            local_extended_block_clock_r <=
                (local_extended_block_clock_cnt_nxt == shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST);
        end
    end

    // input buffer: a stall downstream loses no word
    shf_pair_buf #(
        .W(shf_pkg::BLK_DATA_W)
    ) u_in_buf (
        .clk(core_clk),
        .rst_n(rst_n_r),
        .in_valid(blk_in_valid),
        .in_ready_r(blk_in_ready),
        .in_data(blk_in_data),
        .out_valid_r(buf_valid),
        .out_ready(take),
        .out_data_r(buf_data)
    );

    // accept only while running and the line register can move
    assign take = (state_r == shf_pkg::SHF_RUN) &
                  (~line_valid_r | line_ready);
    assign fire = take & buf_valid;
    // framer state: runs from a local clock edge, stops on a phase slip
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= shf_pkg::SHF_WAIT_EDGE;
        end else begin
            unique case (state_r)
                shf_pkg::SHF_WAIT_EDGE: begin
                    // extended multiblocks start on a clock edge
                    if (!sysref_edge &&
                        local_extended_block_clock_cnt_r == shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST) begin
                        state_r <= shf_pkg::SHF_RUN; // [R24]
                    end
                end
                shf_pkg::SHF_RUN: begin
                    // a sysref off the boundary moves the phase
                    if (sysref_edge && !phase_ok) begin
                        state_r <= shf_pkg::SHF_WAIT_EDGE; // [R4]
                    end
                end
            endcase
        end
    end

    // registered alignment indication
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            aligned_r <= 1'b0;
        end else begin
            aligned_r <= (state_r == shf_pkg::SHF_RUN);
        end
    end

    // block and multiblock position, restarted while waiting
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            blk_idx_r <= '0;
            mb_idx_r <= '0;
        end else if (state_r == shf_pkg::SHF_WAIT_EDGE) begin
            blk_idx_r <= '0;
            mb_idx_r <= '0;
        end else if (fire) begin
            // 32 blocks, then the next multiblock
            blk_idx_r <= blk_idx_r + 5'h01; // [R2]
            if (blk_idx_r == shf_pkg::IDX_LAST) begin
                if (emb_last) begin
                    mb_idx_r <= '0; // [R3]
                end else begin
                    mb_idx_r <= mb_idx_r + 8'h01;
                end
            end
        end
    end

    // serial crc over the 64 payload bits, bit 0 sent first
    function automatic logic [11:0] crc_step(
        input logic [11:0] c,
        input logic [63:0] d
    );
        logic [11:0] s;
        logic fb;
        s = c;
        fb = 1'b0;
        for (int i = 0; i < shf_pkg::BLK_DATA_W; i++) begin
            fb = s[11] ^ d[i];
            s = {s[10:0], 1'b0};
            if (fb) begin
                s = s ^ shf_pkg::CRC_POLY; // [R18]
            end
        end
        return s;
    endfunction

    assign crc_nxt = crc_step(crc_run_r, buf_data); // [R17]
    // running stages cleared each multiblock, parity held for the next
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            crc_run_r <= shf_pkg::CRC_RST;
            crc_hold_r <= shf_pkg::CRC_RST;
        end else if (state_r == shf_pkg::SHF_WAIT_EDGE) begin
            crc_run_r <= shf_pkg::CRC_RST;
            crc_hold_r <= shf_pkg::CRC_RST;
        end else if (fire) begin
            if (blk_idx_r == shf_pkg::IDX_LAST) begin
                // all 2048 bits seen: latch parity, clear stages
                crc_hold_r <= crc_nxt; // [R17] [R19]
                crc_run_r <= shf_pkg::CRC_RST; // [R19]
            end else begin
                crc_run_r <= crc_nxt;
            end
        end
    end

    assign emb_last = (mb_idx_r == e_cfg_r); // [R14]
    // crc-12 stream word; the ones keep 00001 unique at the end
    always_comb begin
        stream_word = '0; // [R21]
        // parity msb first, three bits per group, every fourth bit skipped
        for (int i = 0; i < 12; i++) begin
            stream_word[i + i / 3] = crc_hold_r[11 - i]; // [R20]
        end
        // fixed ones at 3, 7, 11, 15, 19, 23 and 21
        for (int i = 3; i < 24; i += 4) begin
            stream_word[i] = 1'b1; // [R20]
        end
        stream_word[21] = 1'b1; // [R20]
        stream_word[shf_pkg::EMB_FLAG_BIT] = emb_last; // [R14]
        stream_word[31] = 1'b1; // [R13]
    end

    // one stream bit per block, block zero carries bit zero
    assign sbit = stream_word[blk_idx_r]; // [R11] [R24]
    // line register: header {v, ~v} in bits 1..0, payload above
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            line_block_r <= '0;
            line_valid_r <= 1'b0;
        end else if (fire) begin
            line_block_r.payload <= buf_data; // [R1]
            line_block_r.hdr <= {sbit, ~sbit}; // [R7] [R8]
            line_valid_r <= 1'b1;
        end else if (line_ready) begin
            line_valid_r <= 1'b0;
        end
    end

    // only the crc-12 content exists; other selections are flagged
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            content_unsupported_r <= 1'b0;
        end else begin
            content_unsupported_r <= // [R12] [R16]
                (sync_header_content_select != shf_pkg::SEL_CRC12);
        end
    end

    // checks on the emitted stream
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_r);
    a_hdr_complement: assert property ( // [R7]
        line_valid_r |-> (line_block_r.hdr[0] != line_block_r.hdr[1]))
        else $error("header bits not complementary");
    a_hdr_encode: assert property ( // [R8]
        fire |=> line_block_r.hdr == {$past(sbit), ~$past(sbit)})
        else $error("header encoding wrong");
    a_payload_pos: assert property ( // [R1]
        fire |=> line_block_r.payload == $past(buf_data))
        else $error("payload not after header");
    a_pilot_one: assert property ( // [R13]
        fire && blk_idx_r == shf_pkg::IDX_LAST |=>
            line_block_r.hdr == 2'b10)
        else $error("multiblock end bit not one");
    a_pilot_zeros: assert property ( // [R13]
        fire && blk_idx_r >= shf_pkg::PILOT_FIRST &&
        blk_idx_r != shf_pkg::IDX_LAST |=> line_block_r.hdr == 2'b01)
        else $error("pilot zeros missing");
    a_cmd_zero: assert property ( // [R21]
        fire && blk_idx_r >= shf_pkg::CMD_HI_FIRST &&
        blk_idx_r < 5'h13 |=> line_block_r.hdr == 2'b01)
        else $error("command bit not zero");
    a_emb_flag: assert property ( // [R14]
        fire && blk_idx_r == 5'h16 |=>
            line_block_r.hdr[1] == $past(mb_idx_r == e_cfg_r))
        else $error("extended end flag wrong");
    a_mb_wrap: assert property ( // [R2]
        fire && blk_idx_r == shf_pkg::IDX_LAST |=>
            blk_idx_r == '0 && crc_run_r == shf_pkg::CRC_RST)
        else $error("multiblock did not wrap and clear");
    a_sysref_phase: assert property ( // [R4]
        sysref_edge |=> local_extended_block_clock_cnt_r == shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST ##1
            local_extended_block_clock_cnt_r == 13'h0001 || $past(sysref_edge))
        else $error("sysref did not reset local clock");
    a_local_extended_block_clock_wrap: assert property ( // [R5]
        local_extended_block_clock_cnt_r == local_extended_block_clock_last && !sysref_edge |=>
            local_extended_block_clock_r && local_extended_block_clock_cnt_r == '0)
        else $error("local clock period wrong");
    a_start_edge: assert property ( // [R24]
        $rose(aligned_r) |-> $past(local_extended_block_clock_cnt_r, 2) == shf_pkg::LOCAL_EXTENDED_BLOCK_CLOCK_RST)
        else $error("framing started off a clock edge");
endmodule
`default_nettype wire

// ===== rtl/shf_dummy_unused.sv
// empty unit: the framer needs no third module
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== tb/shf_rx_model.sv
// receiver model: takes line blocks, stalls on request, screens headers
`timescale 1ns/1ns
`default_nettype none
module shf_rx_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire shf_pkg::shf_line_t line_block_r,
    input wire logic line_valid_r,
    output var logic line_ready,
    input wire logic hold,
    input wire logic slow,
    input wire logic clr
);
    shf_pkg::shf_line_t blk [0:127]; // every block taken, in order
    int n; // blocks taken since the last clear
    int hdr_err; // headers seen as 00 or 11
    logic [1:0] ph_r; // slow mode phase

    // ready moves just after an edge; slow mode takes one block in four
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_ready <= 1'b0;
            ph_r <= 2'h0;
        end else begin
            ph_r <= ph_r + 2'h1;
            line_ready <= !hold && (!slow || ph_r == 2'h3);
        end
    end

    // capture each block taken and look for a broken header
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            n <= 0;
            hdr_err <= 0;
        end else if (clr) begin
            n <= 0;
        end else if (line_valid_r && line_ready) begin
            blk[n[6:0]] <= line_block_r;
            n <= n + 1;
            if ((line_block_r.hdr[0] ^ line_block_r.hdr[1]) !== 1'b1) begin
                hdr_err <= hdr_err + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/shf_framer_tb.sv
// self-checking bench of the lane framer against a receiver model
`timescale 1ns/1ns
`default_nettype none
module shf_framer_tb;
    logic core_clk = 1'b0; // 250 mhz core clock
    logic arst_n = 1'b0; // board reset, active low
    logic sysref = 1'b0; // local clock reset pin
    logic [shf_pkg::E_W-1:0] e_minus1 = 8'h00; // extended length minus one
    logic [shf_pkg::SEL_W-1:0] sel = 2'h0; // header content select
    logic in_valid = 1'b0; // source word valid
    logic [63:0] in_data = 64'h0; // source word
    logic hold = 1'b0; // receiver refuses everything
    logic slow = 1'b0; // receiver takes one block in four
    logic clr = 1'b0; // receiver restarts its count
    wire logic in_ready; // framer accepts a word
    wire logic line_valid; // block on the line
    wire logic line_ready; // receiver takes the block
    wire logic local_extended_block_clock; // local clock pulse
    wire logic aligned; // framer running
    wire logic unsup; // content select not built
    wire shf_pkg::shf_line_t line_blk; // line block
    int n_mismatch = 0;
    int checks_done = 0;

    // free running core clock
    always #2 core_clk = ~core_clk;

    shf_framer dut (.core_clk(core_clk), .arst_n(arst_n), .sysref(sysref),
        .e_minus1(e_minus1), .sync_header_content_select(sel),
        .blk_in_valid(in_valid), .blk_in_ready(in_ready),
        .blk_in_data(in_data), .line_block_r(line_blk),
        .line_valid_r(line_valid), .line_ready(line_ready),
        .local_extended_block_clock_r(local_extended_block_clock), .aligned_r(aligned),
        .content_unsupported_r(unsup));

    shf_rx_model rx (.core_clk(core_clk), .arst_n(arst_n),
        .line_block_r(line_blk), .line_valid_r(line_valid),
        .line_ready(line_ready), .hold(hold), .slow(slow), .clr(clr));

    // flag comparison
    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // word or count comparison
    task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // step to just after the next rising edge
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // payload pattern of word i
    function automatic logic [63:0] word(input int i);
        return {i[15:0] ^ 16'hc3a5, 16'h0f1e, ~i[15:0], i[15:0] * 16'h9e37};
    endfunction

    // serial parity of 32 words, bit 0 of each word first
    function automatic logic [11:0] crc_of(input int base);
        logic [11:0] c;
        logic [63:0] d;
        logic fb;
        c = 12'h000;
        for (int w = 0; w < 32; w++) begin
            d = word(base + w);
            for (int k = 0; k < 64; k++) begin
                fb = d[k] ^ c[11];
                c = {c[10:0], 1'b0} ^ (fb ? 12'h987 : 12'h000);
            end
        end
        return c;
    endfunction

    // expected stream word: fixed ones, parity groups, end flag
    function automatic logic [31:0] exp_sw(input logic [11:0] c,
                                           input logic emb);
        logic [31:0] w;
        w = 32'h80a88888;
        for (int i = 0; i < 4; i++) begin
            w[4*i] = c[11-3*i];
            w[4*i+1] = c[10-3*i];
            w[4*i+2] = c[9-3*i];
        end
        w[22] = emb;
        return w;
    endfunction

    // hold one word until the framer takes it
    task automatic send(input logic [63:0] d);
        int g;
        g = 0;
        in_valid = 1'b1;
        in_data = d;
        while (in_ready !== 1'b1 && g < 500) begin
            tick();
            g++;
        end
        if (g == 500) n_mismatch++;
        tick();
    endtask

    // send a run of pattern words
    task automatic send_run(input int base, input int cnt);
        for (int i = 0; i < cnt; i++) send(word(base + i));
        in_valid = 1'b0;
    endtask

    // wait until the receiver holds cnt blocks
    task automatic wait_rx(input int cnt);
        int g;
        g = 0;
        while (rx.n < cnt && g < 2000) begin
            tick();
            g++;
        end
        cmp_bit(rx.n >= cnt, 1'b1);
    endtask

    // judge one received multiblock
    task automatic check_mb(input int first, input int base, input logic emb,
                            input logic [11:0] c);
        logic [31:0] sw;
        for (int b = 0; b < 32; b++) begin
            sw[b] = rx.blk[first + b].hdr[1];
            cmp_word(rx.blk[first + b].payload, word(base + b));
        end
        cmp_word({32'h0, sw},
                 {32'h0, exp_sw(c, emb)});
        // one multiblock finds the end: the pattern stands only at the end
        for (int i = 0; i < 27; i++) begin
            cmp_bit(sw[i +: 5] == 5'h10, 1'b0);
        end
    endtask

    // cycles from one local clock pulse to the next
    task automatic t_local_extended_block_clock(input int exp);
        int g;
        g = 0;
        while (local_extended_block_clock !== 1'b1 && g < 300) begin
            tick();
            g++;
        end
        g = 0;
        do begin
            tick();
            g++;
        end while (local_extended_block_clock !== 1'b1 && g < 300);
        cmp_word(64'(g), 64'(exp));
    endtask

    // outputs after reset release
    task automatic t_reset();
        cmp_bit(line_valid, 1'b0);
        cmp_bit(in_ready, 1'b1);
        cmp_bit(unsup, 1'b0);
    endtask

    // two multiblocks; the second carries the first one's parity
    task automatic t_stream();
        send_run(0, 64);
        wait_rx(64);
        check_mb(0, 0, 1'b1, 12'h000);
        check_mb(32, 32, 1'b1, crc_of(0));
        cmp_bit(aligned, 1'b1);
    endtask

    // receiver stalls until input is refused, then drains slowly
    task automatic t_stall();
        int k;
        hold = 1'b1;
        k = 0;
        while (in_ready === 1'b1 && k < 8) begin
            in_valid = 1'b1;
            in_data = word(64 + k);
            tick();
            k++;
        end
        in_valid = 1'b0;
        cmp_bit(k >= 2 && k <= 6, 1'b1);
        repeat (4) tick();
        cmp_bit(in_ready, 1'b0);
        hold = 1'b0;
        slow = 1'b1;
        send_run(64 + k, 32 - k);
        wait_rx(96);
        check_mb(64, 64, 1'b1, crc_of(32));
        slow = 1'b0;
    endtask

    // every select other than zero is flagged; zero clears it
    task automatic t_select();
        for (int s = 1; s < 4; s++) begin
            sel = s[1:0];
            tick();
            cmp_bit(unsup, 1'b1);
            sel = 2'h0;
            tick();
            cmp_bit(unsup, 1'b0);
        end
    endtask

    // sysref out of phase with e of two realigns the framing
    task automatic t_sysref();
        int g;
        g = 0;
        while (local_extended_block_clock !== 1'b1 && g < 300) begin
            tick();
            g++;
        end
        repeat (10) tick();
        e_minus1 = 8'h01;
        sysref = 1'b1;
        g = 0;
        do begin
            tick();
            g++;
        end while (local_extended_block_clock !== 1'b1 && g < 20);
        cmp_word(64'(g), 64'h4);
        sysref = 1'b0;
        clr = 1'b1;
        tick();
        clr = 1'b0;
        t_local_extended_block_clock(64);
        send_run(200, 64);
        wait_rx(64);
        check_mb(0, 200, 1'b0, 12'h000);
        check_mb(32, 232, 1'b1, crc_of(200));
    endtask

    // periodic sysref on the period boundary leaves framing alone
    task automatic t_inphase();
        for (int r = 0; r < 2; r++) begin
            t_local_extended_block_clock(64);
            repeat (60) tick();
            sysref = 1'b1;
            repeat (4) tick();
            cmp_bit(local_extended_block_clock, 1'b1);
            tick();
            cmp_bit(aligned, 1'b1);
            sysref = 1'b0;
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        repeat (3) tick();
        t_reset();
        t_local_extended_block_clock(32);
        t_stream();
        t_stall();
        t_select();
        t_sysref();
        t_inphase();
        cmp_word(64'(rx.hdr_err), 64'h0);
        complete_run();
    end

    // watchdog well beyond the expected run length
    initial begin
        #80000;
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
